// ==== shared/dual_timer_pkg.sv ====
/*
  constants of the dual timer unit: register indices and byte addresses, control field
  positions, reset values and the tick timing derived from the core clock.
  assumes a 40 MHz core clock and a 32-bit AHB-Lite bus with one word per register.
*/

`default_nettype none

package dual_timer_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_PS   = 25000;             // 40 MHz core clock
  localparam int unsigned TIME_UNIT_PS    = CLK_PERIOD_PS / 2; // basic_time_unit
  localparam int unsigned MIN_RES_UNITS   = 8;                 // finest resolution
  // least time, so round up to whole cycles
  localparam int unsigned MIN_TICK_CYCLES =
    (MIN_RES_UNITS * TIME_UNIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PRESC_W         = 12;                // prescaler counter width

  // register indices; byte address is four times the index
  localparam logic [15:0] AUX_CTRL_IDX   = 16'hff40;
  localparam logic [15:0] CORE_CTRL_IDX  = 16'hff42;
  localparam logic [15:0] AUX_CNT_IDX    = 16'hff44;
  localparam logic [15:0] CORE_CNT_IDX   = 16'hff46;
  localparam logic [15:0] CAPTURE_RELOAD_REG_IDX     = 16'hff48;
  localparam logic [15:0] IRQ_STATUS_IDX = 16'hff4a;
  localparam logic [15:0] IRQ_CTRL_IDX   = 16'hff6a; // capture_reload_irq_control

  localparam logic [31:0] AUX_CTRL_ADDR   = {14'h0000, AUX_CTRL_IDX, 2'b00};
  localparam logic [31:0] CORE_CTRL_ADDR  = {14'h0000, CORE_CTRL_IDX, 2'b00};
  localparam logic [31:0] AUX_CNT_ADDR    = {14'h0000, AUX_CNT_IDX, 2'b00};
  localparam logic [31:0] CORE_CNT_ADDR   = {14'h0000, CORE_CNT_IDX, 2'b00};
  localparam logic [31:0] CAPTURE_RELOAD_REG_ADDR     = {14'h0000, CAPTURE_RELOAD_REG_IDX, 2'b00};
  localparam logic [31:0] IRQ_STATUS_ADDR = {14'h0000, IRQ_STATUS_IDX, 2'b00};
  localparam logic [31:0] IRQ_CTRL_ADDR   = {14'h0000, IRQ_CTRL_IDX, 2'b00};

  // control fields shared by both timers, except the aux-only chain bit
  localparam int unsigned CTL_PRESC_LSB = 0;  // 3-bit prescaler select
  localparam int unsigned CTL_EXT_CLK   = 3;  // count pin rising edges
  localparam int unsigned CTL_CHAIN     = 4;  // aux only: count toggle latch changes
  localparam int unsigned CTL_DOWN      = 5;  // count down
  localparam int unsigned CTL_XDIR_EN   = 6;  // direction pin enable
  localparam int unsigned CTL_RUN       = 7;  // timer runs
  // aux only
  localparam int unsigned CTL_CAP_RISE  = 8;  // capture on rising edge
  localparam int unsigned CTL_CAP_FALL  = 9;  // capture on falling edge
  localparam int unsigned CTL_CAP_CLR   = 10; // clear aux after capture
  // core only
  localparam int unsigned CTL_TOGGLE_OE = 8;  // drive toggle output pin
  localparam int unsigned CTL_RELOAD_EN = 9;  // reload on wrap
  localparam int unsigned CTL_CAPCOM_A  = 10; // wrap pulses to capcom_timer_a
  localparam int unsigned CTL_CAPCOM_B  = 11; // wrap pulses to capcom_timer_b

  localparam logic [15:0] AUX_CTRL_WMASK  = 16'h07ff;
  localparam logic [15:0] CORE_CTRL_WMASK = 16'h0fef;

  // status and mask layout
  localparam int unsigned ST_AUX_WRAP  = 0;
  localparam int unsigned ST_CORE_WRAP = 1;
  localparam int unsigned ST_CAPTURE   = 2;
  localparam int unsigned ST_TOGGLE    = 3; // live latch level, not sticky
  localparam int unsigned ST_W         = 3;

  // reset values
  localparam logic [15:0]     CTRL_RST   = 16'h0000;
  localparam logic [15:0]     CNT_RST    = 16'h0000;
  localparam logic [15:0]     CAPTURE_RELOAD_REG_RST = 16'h0000;
  localparam logic [ST_W-1:0] STATUS_RST = 3'h0;
  localparam logic [ST_W-1:0] MASK_RST   = 3'h0;

  // bus data-phase state, gray coded
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ  = 2'b11
  } bus_phase_t;

endpackage : dual_timer_pkg

`default_nettype wire

// ==== core/timer_counter16.sv ====
/*
  one 16-bit up/down timer with software load, clear and reload on wrap.
  assumes tick and control come from the caller in the core clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module timer_counter16
  import dual_timer_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        clk_en_in,
  // control
  input  wire logic        tick_in,
  input  wire logic        down_in,
  input  wire logic        clear_in,
  input  wire logic        wr_in,
  input  wire logic [15:0] wr_val_in,
  input  wire logic        reload_en_in,
  input  wire logic [15:0] reload_val_in,
  // state
  output logic      [15:0] count_out,
  output logic             wrap_out
);

  logic [15:0] cnt_r;   // counter value
  logic [15:0] cnt_nxt; // next value
  logic        at_end;  // next tick leaves the range

  // all ones going up, zero going down
  assign at_end   = down_in ? (cnt_r == 16'h0000) : (cnt_r == 16'hffff);
  assign wrap_out = tick_in & at_end & ~wr_in & ~clear_in;

  // priority: software write, clear, reload, count
  always_comb begin
    cnt_nxt = cnt_r;
    if (wr_in) begin
      cnt_nxt = wr_val_in;
    end else if (clear_in) begin
      cnt_nxt = 16'h0000;
    end else if (wrap_out && reload_en_in) begin
      cnt_nxt = reload_val_in;
    end else if (tick_in) begin
      // natural wrap of the 16-bit sum covers both directions
      cnt_nxt = down_in ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
    end
  end

  // counter flop
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cnt_r <= CNT_RST;
    end else if (clk_en_in) begin
      cnt_r <= cnt_nxt;
    end
  end

  assign count_out = cnt_r;

endmodule // timer_counter16

`default_nettype wire

// ==== core/dual_timer_unit.sv ====
/*
  dual timer unit: aux and core 16-bit timers, toggle latch, capture/reload register,
  sticky interrupt status with mask, and an AHB-Lite register slave.
  assumes pins are synchronous to core_clk_in and one bus master with zero-wait slave.
*/
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module dual_timer_unit
  import dual_timer_pkg::*;
(
  // clock, reset, enable
  input  wire logic        core_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        clk_en_in,
  // ahb-lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // timer pins
  input  wire logic        aux_count_input_pin_in,
  input  wire logic        core_count_input_pin_in,
  input  wire logic        aux_direction_control_pin_in,
  input  wire logic        core_direction_control_pin_in,
  input  wire logic        capture_input_pin_in,
  output logic             toggle_output_pin_out,
  // capcom clock pulses
  output logic             capcom_timer_a_clk_out,
  output logic             capcom_timer_b_clk_out,
  // interrupt
  output logic             irq_out
);

  // registers
  logic [15:0]     aux_ctrl_r;           // aux control
  logic [15:0]     core_ctrl_r;          // core control
  logic [15:0]     capture_reload_reg_r; // shared capture/reload value
  logic [ST_W-1:0] irq_status_r;         // sticky events
  logic [ST_W-1:0] irq_mask_r;           // capture_reload_irq_control
  logic            core_toggle_latch_r;  // flips on core wraps
  logic            toggle_pin_r;         // pin copy of latch
  logic            capcom_a_r;           // capcom pulse a
  logic            capcom_b_r;           // capcom pulse b
  logic            irq_r;                // level interrupt
  logic [PRESC_W-1:0] presc_r;           // free-running prescaler
  logic [1:0]      cnt_pin_prev_r;       // count pins, last cycle
  logic            cap_pin_prev_r;       // capture pin, last cycle
  logic            latch_prev_r;         // toggle latch, last cycle
  logic [31:0]     hrdata_r;             // read data
  bus_phase_t      phase_r;              // data phase kind
  logic [31:0]     wr_addr_r;            // address of pending write

  // per-timer vectors, index 0 aux, 1 core
  logic [1:0][15:0] ctrl_w;
  logic [1:0][15:0] count_w;
  logic [1:0]       cnt_pin_w;
  logic [1:0]       dir_pin_w;
  logic [1:0]       tick_w;
  logic [1:0]       down_w;
  logic [1:0]       wrap_w;
  logic [1:0]       cnt_wr_w;
  logic [1:0]       clear_w;
  logic [1:0]       reload_en_w;

  assign ctrl_w    = {core_ctrl_r, aux_ctrl_r};
  assign cnt_pin_w = {core_count_input_pin_in, aux_count_input_pin_in};
  assign dir_pin_w = {core_direction_control_pin_in, aux_direction_control_pin_in};

  // bus decode: only whole-word transfers are taken
  wire         bus_take  = hsel_in & htrans_in[1] & hready_in & (hsize_in == 3'b010);
  wire         bus_rd    = bus_take & ~hwrite_in;
  wire         bus_wr    = bus_take & hwrite_in;
  wire         wr_phase  = (phase_r == PH_WRITE);
  wire [15:0]  wdata16   = hwdata_in[15:0];
  wire         wr_aux_c  = wr_phase & (wr_addr_r == AUX_CTRL_ADDR);
  wire         wr_core_c = wr_phase & (wr_addr_r == CORE_CTRL_ADDR);
  wire         wr_aux_n  = wr_phase & (wr_addr_r == AUX_CNT_ADDR);
  wire         wr_core_n = wr_phase & (wr_addr_r == CORE_CNT_ADDR);
  wire         wr_capture_reload_reg = wr_phase & (wr_addr_r == CAPTURE_RELOAD_REG_ADDR);
  wire         wr_mask   = wr_phase & (wr_addr_r == IRQ_CTRL_ADDR);
  wire         rd_status = bus_rd & (haddr_in == IRQ_STATUS_ADDR);

  // capture edge detection on the synchronous capture pin
  wire cap_rise  = capture_input_pin_in & ~cap_pin_prev_r;
  wire cap_fall  = ~capture_input_pin_in & cap_pin_prev_r;
  wire capture_w = (cap_rise & aux_ctrl_r[CTL_CAP_RISE]) |
                   (cap_fall & aux_ctrl_r[CTL_CAP_FALL]);
  wire latch_chg = core_toggle_latch_r ^ latch_prev_r;   // each change is one core wrap

  // software writes win over hardware loads on the same count
  assign cnt_wr_w    = {wr_core_n, wr_aux_n};
  assign clear_w     = {1'b0, capture_w & aux_ctrl_r[CTL_CAP_CLR]};
  assign reload_en_w = {core_ctrl_r[CTL_RELOAD_EN], 1'b0};

  // per-timer clock source, direction and counter
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_timer
      wire [2:0]  sel      = ctrl_w[gi][CTL_PRESC_LSB +: 3];
      // period is MIN_TICK_CYCLES shifted by the select, never finer than 8 units
      wire [PRESC_W-1:0] pmask =
        PRESC_W'((MIN_TICK_CYCLES << sel) - 1);
      wire        pre_tick = ((presc_r & pmask) == '0);
      wire        ext_tick = cnt_pin_w[gi] & ~cnt_pin_prev_r[gi];
      wire        chained  = (gi == 0) && ctrl_w[gi][CTL_CHAIN];
      wire        src_tick;

      // chained aux counts latch changes, else pin edges or prescaler
      assign src_tick = chained ? latch_chg :
                        ctrl_w[gi][CTL_EXT_CLK] ? ext_tick :
                        pre_tick;
      assign tick_w[gi] = ctrl_w[gi][CTL_RUN] & src_tick;
      // direction pin inverts the software direction while enabled
      assign down_w[gi] = ctrl_w[gi][CTL_DOWN] ^
                          (ctrl_w[gi][CTL_XDIR_EN] & dir_pin_w[gi]);

      timer_counter16 u_timer (
        .clk_in        (core_clk_in),
        .resetn_in     (resetn_in),
        .clk_en_in     (clk_en_in),
        .tick_in       (tick_w[gi]),
        .down_in       (down_w[gi]),
        .clear_in      (clear_w[gi]),
        .wr_in         (cnt_wr_w[gi]),
        .wr_val_in     (wdata16),
        .reload_en_in  (reload_en_w[gi]),
        .reload_val_in (capture_reload_reg_r),
        .count_out     (count_w[gi]),
        .wrap_out      (wrap_w[gi])
      );
    end
  endgenerate

  wire core_wrap = wrap_w[1];
  wire aux_wrap  = wrap_w[0];

  // sticky events; a set beats a read-clear in the same cycle
  wire [ST_W-1:0] ev_set = {capture_w, core_wrap, aux_wrap};
  wire [ST_W-1:0] ev_clr = rd_status ? {ST_W{1'b1}} : {ST_W{1'b0}};
  wire [ST_W-1:0] status_nxt = (irq_status_r & ~ev_clr) | ev_set;

  // read mux, sampled in the address phase
  wire [15:0] status_view = {12'h000, core_toggle_latch_r, irq_status_r};
  wire [15:0] rd_mux =
    (haddr_in == AUX_CTRL_ADDR)   ? aux_ctrl_r :
    (haddr_in == CORE_CTRL_ADDR)  ? core_ctrl_r :
    (haddr_in == AUX_CNT_ADDR)    ? count_w[0] :
    (haddr_in == CORE_CNT_ADDR)   ? count_w[1] :
    (haddr_in == CAPTURE_RELOAD_REG_ADDR)     ? capture_reload_reg_r :
    (haddr_in == IRQ_STATUS_ADDR) ? status_view :
    (haddr_in == IRQ_CTRL_ADDR)   ? {13'h0000, irq_mask_r} :
    16'h0000; // unmapped reads zero

  // capture beats software write; the old value feeds any reload this cycle
  wire [15:0] capture_reload_reg_nxt = capture_w ? count_w[0] :
                           wr_capture_reload_reg ? wdata16 : capture_reload_reg_r;

  // bus phase tracking and read data
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      phase_r   <= PH_IDLE;
      wr_addr_r <= 32'h0000_0000;
      hrdata_r  <= 32'h0000_0000;
    end else if (clk_en_in) begin
      phase_r   <= bus_wr ? PH_WRITE : bus_rd ? PH_READ : PH_IDLE;
      wr_addr_r <= bus_wr ? haddr_in : wr_addr_r;
      hrdata_r  <= bus_rd ? {16'h0000, rd_mux} : hrdata_r;
    end
  end

  // control and mask registers
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      aux_ctrl_r  <= CTRL_RST;
      core_ctrl_r <= CTRL_RST;
      irq_mask_r  <= MASK_RST;
    end else if (clk_en_in) begin
      if (wr_aux_c) begin
        aux_ctrl_r <= wdata16 & AUX_CTRL_WMASK;
      end
      if (wr_core_c) begin
        core_ctrl_r <= wdata16 & CORE_CTRL_WMASK;
      end
      if (wr_mask) begin
        irq_mask_r <= wdata16[ST_W-1:0];
      end
    end
  end

  // capture/reload register and sticky status
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      capture_reload_reg_r <= CAPTURE_RELOAD_REG_RST;
      irq_status_r         <= STATUS_RST;
    end else if (clk_en_in) begin
      capture_reload_reg_r <= capture_reload_reg_nxt;
      irq_status_r         <= status_nxt;
    end
  end

  // toggle latch and the pulses derived from core wraps
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      core_toggle_latch_r <= 1'b0;
      latch_prev_r        <= 1'b0;
      toggle_pin_r        <= 1'b0;
      capcom_a_r          <= 1'b0;
      capcom_b_r          <= 1'b0;
    end else if (clk_en_in) begin
      core_toggle_latch_r <= core_toggle_latch_r ^ core_wrap;
      latch_prev_r        <= core_toggle_latch_r;
      toggle_pin_r        <= core_ctrl_r[CTL_TOGGLE_OE] &
                             (core_toggle_latch_r ^ core_wrap);
      capcom_a_r          <= core_wrap & core_ctrl_r[CTL_CAPCOM_A];
      capcom_b_r          <= core_wrap & core_ctrl_r[CTL_CAPCOM_B];
    end
  end

  // prescaler, pin history and interrupt level
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      presc_r        <= '0;
      cnt_pin_prev_r <= 2'b00;
      cap_pin_prev_r <= 1'b0;
      irq_r          <= 1'b0;
    end else if (clk_en_in) begin
      presc_r        <= presc_r + PRESC_W'(1);
      cnt_pin_prev_r <= cnt_pin_w;
      cap_pin_prev_r <= capture_input_pin_in;
      irq_r          <= |(status_nxt & irq_mask_r);
    end
  end

  // outputs; ready follows the clock enable so a frozen unit stalls the bus
  assign hrdata_out             = hrdata_r;
  assign hreadyout_out          = clk_en_in;
  assign hresp_out              = 1'b0;
  assign toggle_output_pin_out  = toggle_pin_r;
  assign capcom_timer_a_clk_out = capcom_a_r;
  assign capcom_timer_b_clk_out = capcom_b_r;
  assign irq_out                = irq_r;

endmodule // dual_timer_unit

`default_nettype wire

// ==== verification/pin_source_model.sv ====
/*
  far-side pin sources for the timer unit: count, direction and capture pins.
  assumes one core clock; every pin changes just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_source_model (
  // clock
  input  wire logic clk_in,
  // pins toward the unit
  output logic      aux_count_out,
  output logic      core_count_out,
  output logic      aux_dir_out,
  output logic      core_dir_out,
  output logic      capture_out
);
  // all pins low until a scenario moves them
  initial begin
    aux_count_out = 1'b0;
    core_count_out = 1'b0;
    aux_dir_out = 1'b0;
    core_dir_out = 1'b0;
    capture_out = 1'b0;
  end

  // two cycles high, then at least two low (three between pulses), so the edge detector never misses one
  task automatic pulse(input bit core, input int n);
    repeat (n) begin
      @(posedge clk_in);
      if (core) begin
        core_count_out <= 1'b1;
      end else begin
        aux_count_out <= 1'b1;
      end
      repeat (2) @(posedge clk_in);
      core_count_out <= 1'b0;
      aux_count_out <= 1'b0;
      repeat (2) @(posedge clk_in);
    end
  endtask

  // level pins: 0 aux direction, 1 core direction, else capture
  task automatic level(input int which, input logic v);
    @(posedge clk_in);
    case (which)
      0: aux_dir_out <= v;
      1: core_dir_out <= v;
      default: capture_out <= v;
    endcase
    repeat (3) @(posedge clk_in);
  endtask
endmodule // pin_source_model
`default_nettype wire

// ==== verification/dual_timer_unit_chk.sv ====
/*
  port-level checker for the dual timer unit.
  assumes it is bound to the unit's top module; one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dual_timer_unit_chk
  import dual_timer_pkg::*;
(
  // clock, reset, enable
  input wire logic        core_clk_in,
  input wire logic        resetn_in,
  input wire logic        clk_en_in,
  // bus
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [2:0]  hsize_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  // pins
  input wire logic        toggle_output_pin_out,
  input wire logic        capcom_timer_a_clk_out,
  input wire logic        capcom_timer_b_clk_out,
  input wire logic        irq_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  // word transfers the slave takes
  wire logic taken = hsel_in & htrans_in[1] & hready_in & (hsize_in == 3'b010) & clk_en_in;
  wire logic rd_st = taken & !hwrite_in & (haddr_in == IRQ_STATUS_ADDR);
  wire logic wr_mask = taken & hwrite_in & (haddr_in == IRQ_CTRL_ADDR);

  okay_resp_a: assert property (hresp_out == 1'b0)
    else $error("bus response not okay");
  ready_enable_a: assert property (hreadyout_out == clk_en_in)
    else $error("ready does not follow clock enable");
  upper_zero_a: assert property (hrdata_out[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  reset_quiet_a: assert property ($rose(resetn_in) |-> hrdata_out == 32'h0
    && !(irq_out | toggle_output_pin_out | capcom_timer_a_clk_out | capcom_timer_b_clk_out))
    else $error("outputs not quiet after reset");
  rdata_stands_a: assert property ($changed(hrdata_out) |-> $past(taken & !hwrite_in))
    else $error("read data moved without a read");
  irq_fall_cause_a: assert property ($fell(irq_out) |-> !$past(resetn_in) || $past(rd_st)
    || $past(wr_mask, 2) || $past(wr_mask, 3))
    else $error("interrupt fell without status read or mask write");
  pulse_a_single_a: assert property (capcom_timer_a_clk_out && clk_en_in |=> !capcom_timer_a_clk_out)
    else $error("capcom a pulse longer than one cycle");
  pulse_b_single_a: assert property (capcom_timer_b_clk_out && clk_en_in |=> !capcom_timer_b_clk_out)
    else $error("capcom b pulse longer than one cycle");
  freeze_hold_a: assert property (!clk_en_in |=> $stable({toggle_output_pin_out, irq_out,
    hrdata_out, capcom_timer_a_clk_out, capcom_timer_b_clk_out}))
    else $error("outputs moved while clock enable low");
endmodule // dual_timer_unit_chk
bind dual_timer_unit dual_timer_unit_chk dual_timer_unit_chk_i (.core_clk_in, .resetn_in,
  .clk_en_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hready_in, .hrdata_out,
  .hreadyout_out, .hresp_out, .toggle_output_pin_out, .capcom_timer_a_clk_out,
  .capcom_timer_b_clk_out, .irq_out);
`default_nettype wire

// ==== verification/tb_top.sv ====
/*
  self-checking bench for the dual timer unit, one task per scenario.
  assumes the pin source model and the bound checker; 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dual_timer_pkg::*;
;
  logic        clk = 1'b0;     // core clock
  logic        resetn = 1'b0;  // sync reset, low active
  logic        clk_en = 1'b1;  // stall control
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;   // words only
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;             // last read data
  wire logic [31:0] hrdata;
  wire logic   hready, hresp, tog, cc_a, cc_b, irq;
  wire logic   aux_cnt, core_cnt, aux_dir, core_dir, cap;
  int          n_errors = 0;
  int          checked = 0;
  int          cycles = 0;
  int          n_cc_a = 0;     // capcom pulses seen
  int          n_cc_b = 0;

  // 25 ns period
  always #12.5 clk = ~clk;

  dual_timer_unit dual_timer_unit_i (.core_clk_in(clk), .resetn_in(resetn), .clk_en_in(clk_en),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .aux_count_input_pin_in(aux_cnt), .core_count_input_pin_in(core_cnt),
    .aux_direction_control_pin_in(aux_dir), .core_direction_control_pin_in(core_dir),
    .capture_input_pin_in(cap), .toggle_output_pin_out(tog), .capcom_timer_a_clk_out(cc_a),
    .capcom_timer_b_clk_out(cc_b), .irq_out(irq));

  pin_source_model pin_source_model_i (.clk_in(clk), .aux_count_out(aux_cnt),
    .core_count_out(core_cnt), .aux_dir_out(aux_dir), .core_dir_out(core_dir), .capture_out(cap));

  // count capcom pulses; frozen cycles are not new pulses
  always @(posedge clk) begin
    if (cc_a === 1'b1 && clk_en) n_cc_a++;
    if (cc_b === 1'b1 && clk_en) n_cc_b++;
  end

  // hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (n_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one single transfer; waits on ready, never on a fixed count
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask

  // reset values, write masks, read-only status, unmapped place
  task automatic t_regs();
    logic [31:0] adr [8] = '{AUX_CTRL_ADDR, CORE_CTRL_ADDR, AUX_CNT_ADDR, CORE_CNT_ADDR,
      CAPTURE_RELOAD_REG_ADDR, IRQ_STATUS_ADDR, IRQ_CTRL_ADDR, 32'h0000_0100};
    foreach (adr[i]) rdc("reset value", adr[i], 32'h0);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, adr[i], 32'hffff_ffff);
      rdc("ctrl mask", adr[i], {16'h0, i ? CORE_CTRL_WMASK : AUX_CTRL_WMASK});
      bus(1'b1, adr[i], 32'h0);
    end
    bus(1'b1, IRQ_STATUS_ADDR, 32'hf);
    rdc("status read only", IRQ_STATUS_ADDR, 32'h0);
    bus(1'b1, adr[7], 32'h5a5a);
    rdc("unmapped", adr[7], 32'h0);
  endtask

  // pin counting both ways, wraps, direction pin, interrupt
  task automatic t_count();
    bus(1'b1, IRQ_CTRL_ADDR, 32'h2);
    bus(1'b1, CORE_CTRL_ADDR, 32'h88);
    pin_source_model_i.pulse(1'b1, 3);
    rdc("pin count up", CORE_CNT_ADDR, 32'h3);
    bus(1'b1, CORE_CNT_ADDR, 32'h1);
    bus(1'b1, CORE_CTRL_ADDR, 32'ha8);
    pin_source_model_i.pulse(1'b1, 2);
    rdc("underflow", CORE_CNT_ADDR, 32'hffff);
    check("irq raised", 32'h1, {31'h0, irq});
    rdc("status wrap", IRQ_STATUS_ADDR, 32'ha);
    check("irq cleared", 32'h0, {31'h0, irq});
    rdc("status cleared", IRQ_STATUS_ADDR, 32'h8);
    bus(1'b1, CORE_CTRL_ADDR, 32'hc8);
    pin_source_model_i.level(1, 1'b1);
    pin_source_model_i.pulse(1'b1, 1);
    rdc("dir pin down", CORE_CNT_ADDR, 32'hfffe);
    pin_source_model_i.level(1, 1'b0);
    pin_source_model_i.pulse(1'b1, 2);
    rdc("overflow", CORE_CNT_ADDR, 32'h0);
  endtask

  // one core wrap: reload, toggle pin, capcom pulses, chained aux
  task automatic t_chain();
    bus(1'b1, IRQ_CTRL_ADDR, 32'h0);
    rdc("masked status", IRQ_STATUS_ADDR, 32'h2);
    bus(1'b1, AUX_CTRL_ADDR, 32'h90);
    bus(1'b1, CAPTURE_RELOAD_REG_ADDR, 32'h1234);
    bus(1'b1, CORE_CNT_ADDR, 32'hffff);
    bus(1'b1, CORE_CTRL_ADDR, 32'hf88);
    n_cc_a = 0;
    n_cc_b = 0;
    pin_source_model_i.pulse(1'b1, 1);
    rdc("reload", CORE_CNT_ADDR, 32'h1234);
    check("toggle pin", 32'h1, {31'h0, tog});
    check("capcom a", 32'h1, 32'(n_cc_a));
    check("capcom b", 32'h1, 32'(n_cc_b));
    rdc("aux chained", AUX_CNT_ADDR, 32'h1);
    check("irq masked", 32'h0, {31'h0, irq});
    rdc("latch status", IRQ_STATUS_ADDR, 32'ha);
    bus(1'b1, CORE_CTRL_ADDR, 32'he88);
    repeat (2) @(posedge clk);
    check("toggle pin off", 32'h0, {31'h0, tog});
  endtask

  // rising capture with clear, then falling capture without
  task automatic t_capture();
    bus(1'b1, IRQ_CTRL_ADDR, 32'h4);
    bus(1'b1, AUX_CTRL_ADDR, 32'h500);
    bus(1'b1, AUX_CNT_ADDR, 32'h55);
    pin_source_model_i.level(2, 1'b1);
    rdc("capture rise", CAPTURE_RELOAD_REG_ADDR, 32'h55);
    rdc("aux cleared", AUX_CNT_ADDR, 32'h0);
    check("capture irq", 32'h1, {31'h0, irq});
    rdc("capture status", IRQ_STATUS_ADDR, 32'hc);
    bus(1'b1, AUX_CTRL_ADDR, 32'h200);
    bus(1'b1, AUX_CNT_ADDR, 32'h66);
    pin_source_model_i.level(2, 1'b0);
    rdc("capture fall", CAPTURE_RELOAD_REG_ADDR, 32'h66);
    rdc("aux kept", AUX_CNT_ADDR, 32'h66);
    // aux pin count across all ones raises the aux wrap status bit
    bus(1'b1, AUX_CNT_ADDR, 32'hffff);
    bus(1'b1, AUX_CTRL_ADDR, 32'h88);
    pin_source_model_i.pulse(1'b0, 1);
    rdc("aux pin wrap", AUX_CNT_ADDR, 32'h0);
    rdc("aux wrap status", IRQ_STATUS_ADDR, 32'hd);
  endtask

  // 64 enabled cycles between sampling reads, with a stall inside
  task automatic t_presc();
    logic [31:0] first;
    bus(1'b1, CORE_CTRL_ADDR, 32'h0);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, CORE_CTRL_ADDR, 32'h80 | 32'(s));
      bus(1'b0, CORE_CNT_ADDR, 32'h0);
      first = rd;
      clk_en <= 1'b0;
      repeat (8) @(posedge clk);
      check("stalled ready", 32'h0, {31'h0, hready});
      clk_en <= 1'b1;
      repeat (61) @(posedge clk);
      rdc("prescaled ticks", CORE_CNT_ADDR, first + (32'h40 >> (s + 2)));
    end
  endtask

  // reset two cycles, then the scenarios
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_count();
    t_chain();
    t_capture();
    t_presc();
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
